// ===== bench/strap_config_top_tb.sv
module strap_config_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    strap_pkg::wb_req_s    wb_req_i = '0;
    strap_pkg::mem_req_s   mem_req_i = '0;
    strap_pkg::strap_cfg_s strap_cfg_o;
    logic [31:0]           wb_dat_o;
    logic [31:0]           rd;
    logic                  wb_ack_o;
    logic                  rom_select_o;
    logic                  load_busy_o;
    logic [15:0]           mem_rdata_o;
    logic [15:0]           data_pin_i;
    logic [15:0]           data_pin_o;
    logic [15:0]           data_pin_oe_o;
    logic [15:0]           strap_data = '0;
    logic [15:0]           ram_data = '0;
    logic [13:1]           addr_pin_i;
    logic [13:1]           addr_pin_o;
    logic [13:1]           addr_pin_oe_o;
    logic [13:1]           strap_addr = '0;
    int                    miscompares = 0;
    int                    checked = 0;
    int                    cycles = 0;

    always #4 clk_i = ~clk_i;

    strap_config_top #(.WORDS(2), .HALF(2)) dut (
        .clk_i, .rst_i, .wb_req_i, .wb_dat_o, .wb_ack_o, .mem_req_i,
        .mem_rdata_o, .data_pin_i, .data_pin_o, .data_pin_oe_o,
        .addr_pin_i, .addr_pin_o, .addr_pin_oe_o, .rom_select_o,
        .strap_cfg_o, .load_busy_o);

    strap_pins_model pins (
        .rst_i, .rom_select_i(rom_select_o), .data_o_i(data_pin_o),
        .data_oe_i(data_pin_oe_o), .addr_o_i(addr_pin_o),
        .addr_oe_i(addr_pin_oe_o), .strap_data_i(strap_data),
        .strap_addr_i(strap_addr), .ram_data_i(ram_data),
        .data_wire_o(data_pin_i), .addr_wire_o(addr_pin_i));

    // ==========================================================
    // shared tasks
    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd);
        wb_req_i <= '{1'b1, 1'b1, we, 4'hf, adr, wd};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req_i <= '0;
        @(posedge clk_i);
    endtask

    // last pattern of the reset wins
    task automatic do_reset(input logic [15:0] d, input logic [13:1] a);
        rst_i <= 1'b1;
        strap_data <= ~d;
        strap_addr <= ~a;
        repeat (6) @(posedge clk_i);
        strap_data <= d;
        strap_addr <= a;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (load_busy_o !== 1'b0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_straps();
        do_reset(16'hb7c4, {3'b101, 1'b0, 1'b1, 8'h69});
        repeat (20) @(posedge clk_i);
        chk(strap_cfg_o.first, 8'hc4);
        chk(strap_cfg_o.second, 8'hb7);
        chk(strap_cfg_o.third, 8'h69);
        chk(strap_cfg_o.host_width, 1'b1);
        chk(strap_cfg_o.cfg_source, 1'b0);
        chk(strap_cfg_o.signature, 3'b101);
        chk(load_busy_o, 1'b0);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'ha0);
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h69);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd[4:3], 2'b01);
        $display("t_straps done");
    endtask

    task automatic t_mem();
        mem_req_i <= '{13'h1abc, 16'h5aa5, 1'b1};
        repeat (2) @(posedge clk_i);
        chk(addr_pin_o, 13'h1abc);
        chk(addr_pin_oe_o, 13'h1fff);
        chk(data_pin_o, 16'h5aa5);
        chk(data_pin_oe_o, 16'hffff);
        ram_data <= 16'h9c36;
        mem_req_i.write <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(data_pin_oe_o, 16'h0);
        chk(mem_rdata_o, 16'h9c36);
        $display("t_mem done");
    endtask

    task automatic t_rom();
        mem_req_i <= '{13'h0, 16'h0003, 1'b1};
        do_reset(16'h0, {3'b000, 1'b1, 1'b0, 8'h00});
        @(posedge clk_i);
        chk(load_busy_o, 1'b1);
        repeat (10) @(posedge clk_i);
        chk(data_pin_oe_o, 16'h0005);
        chk(rom_select_o, 1'b1);
        wait_idle();
        chk(rom_select_o, 1'b0);
        chk(strap_cfg_o.first, 8'h2d);
        chk(strap_cfg_o.second, 8'h1e);
        chk(strap_cfg_o.third, 8'h2e);
        chk(data_pin_oe_o, 16'hffff);
        chk(data_pin_o[2:0], 3'h3);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h1e2d);
        wb(1'b0, 8'h44, 32'h0);
        chk(rd, 32'h1f2e);
        wb(1'b0, 8'h00, 32'h0);
        chk(rd[2], 1'b1);
        $display("t_rom done");
    endtask

    task automatic t_regs();
        wb(1'b1, 8'h04, 32'hff);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2d);
        wb(1'b0, 8'h2c, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h00, 32'h1);
        @(posedge clk_i);
        chk(load_busy_o, 1'b1);
        wait_idle();
        chk(strap_cfg_o.first, 8'h2d);
        $display("t_regs done");
    endtask

    initial begin
        @(posedge clk_i);
        t_straps();
        t_mem();
        t_rom();
        t_regs();
        wrap_up();
    end
endmodule

// ===== bench/strap_pins_model.sv
module strap_pins_model (
    // control seen from the device
    input  wire logic        rst_i,
    input  wire logic        rom_select_i,
    input  wire logic [15:0] data_o_i,
    input  wire logic [15:0] data_oe_i,
    input  wire logic [13:1] addr_o_i,
    input  wire logic [13:1] addr_oe_i,
    // board setup
    input  wire logic [15:0] strap_data_i,
    input  wire logic [13:1] strap_addr_i,
    input  wire logic [15:0] ram_data_i,
    // resolved pin levels
    output logic [15:0]      data_wire_o,
    output logic [13:1]      addr_wire_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0]  rises   = '0;
    logic [8:0]  cmd     = '0;
    logic [15:0] word    = '0;
    logic        rom_bit = 1'b0;

    // ==========================================================
    // serial rom: command in on rising clock, data out on falling
    always @(posedge rom_select_i) rises = '0;
    always @(posedge data_o_i[2]) begin
        if (rom_select_i && rises < 9) cmd = {cmd[7:0], data_o_i[0]};
        if (rom_select_i) rises = rises + 5'h1;
    end
    always @(negedge data_o_i[2]) begin
        if (rom_select_i && rises == 9) begin
            word = 16'h1e2d + {2'h0, cmd[5:0], 2'h0, cmd[5:0]};
            rom_bit = 1'b0;
        end else if (rom_select_i && rises > 9) begin
            rom_bit = word[15];
            word = {word[14:0], 1'b0};
        end
    end

    // ==========================================================
    // strap resistors in reset, else rom or ram
    always_comb begin
        for (int i = 0; i < 16; i++)
            data_wire_o[i] = data_oe_i[i] ? data_o_i[i]
                : rst_i ? strap_data_i[i]
                : (rom_select_i && i == 1) ? rom_bit : ram_data_i[i];
        addr_wire_o = (addr_oe_i & addr_o_i) | (~addr_oe_i
                      & (rst_i ? strap_addr_i : ~strap_addr_i));
    end
endmodule

// ===== common/strap_pkg.sv
package strap_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int ROM_HALF_NS   = 500;
    localparam int ROM_HALF_CYC  =
        (ROM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // serial rom geometry
    localparam int         ROM_WORDS  = 16;
    localparam int         ROM_ADDR_W = 6;
    localparam int         ROM_DATA_W = 16;
    localparam logic [2:0] ROM_READ_OP = 3'h6;

    // ==========================================================
    // register map, byte addresses; prom window selected by address bits 7:6
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_FIRST  = 8'h04;
    localparam logic [7:0] OFS_SECOND = 8'h08;
    localparam logic [7:0] OFS_THIRD  = 8'h0c;
    localparam logic [7:0] OFS_SIGN   = 8'h10;
    localparam logic [1:0] OFS_PROM   = 2'h1;

    // ctrl/status and signature bit positions
    localparam int CTRL_RELOAD  = 0;
    localparam int ST_BUSY      = 1;
    localparam int ST_DONE      = 2;
    localparam int ST_WIDTH16   = 3;
    localparam int ST_SRC_ROM   = 4;
    localparam int SIGN_LSB     = 5;

    // pin positions
    localparam int PIN_WIDTH    = 9;
    localparam int PIN_SOURCE   = 10;
    localparam int PIN_SIGN_LSB = 11;
    localparam logic [15:0] SERIAL_OE = 16'h0005;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
        logic [7:0] third;
        logic       host_width;
        logic       cfg_source;
        logic [2:0] signature;
    } strap_cfg_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic [13:1] addr;
        logic [15:0] wdata;
        logic        write;
    } mem_req_s;

endpackage

// ===== design/serial_rom_reader.sv
module serial_rom_reader #(
    parameter int WORDS  = strap_pkg::ROM_WORDS,
    parameter int ADDR_W = strap_pkg::ROM_ADDR_W,
    parameter int DATA_W = strap_pkg::ROM_DATA_W,
    parameter int HALF   = strap_pkg::ROM_HALF_CYC
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              start_i,
    output logic                   busy_o,
    output logic                   done_o,
    // serial pins
    output logic                   cs_o,
    output logic                   sk_o,
    output logic                   do_o,
    input  wire logic              di_i,
    // words read
    output logic                   word_valid_o,
    output logic [$clog2(WORDS)-1:0] word_idx_o,
    output logic [DATA_W-1:0]      word_o
);
    localparam int NCMD = 3 + ADDR_W;
    localparam int DW   = $clog2(HALF + 1);
    localparam int IW   = $clog2(WORDS);
    localparam int CW   = $clog2(NCMD + DATA_W + 1);

    typedef enum logic [1:0] {IDLE, CMD, DATA, GAP} phase_e;

    typedef struct packed {
        phase_e            phase;
        logic [DW-1:0]     div;
        logic [CW-1:0]     cnt;
        logic [IW-1:0]     idx;
        logic [DATA_W-1:0] sh;
        logic              cs;
        logic              sk;
        logic              dout;
        logic              valid;
        logic              done;
    } rd_s;

    rd_s q, d;
    logic tick;

    function automatic logic [NCMD-1:0] cmd_of(input logic [IW-1:0] i);
        cmd_of = {strap_pkg::ROM_READ_OP, ADDR_W'(i)};
    endfunction

    function automatic logic cmd_bit(input logic [IW-1:0] i,
                                     input int            pos);
        logic [NCMD-1:0] c;
        c       = cmd_of(i);
        cmd_bit = c[pos];
    endfunction

    // ==========================================================
    // sequencer
    always_comb begin
        d       = q;
        d.valid = 1'b0;
        d.done  = 1'b0;
        tick    = (q.div == '0);
        d.div   = tick ? DW'(HALF - 1) : q.div - 1'b1;
        case (q.phase)
            IDLE: begin
                d.div = DW'(HALF - 1);
                if (start_i) begin
                    d.phase = CMD;
                    d.cs    = 1'b1;
                    d.idx   = '0;
                    d.cnt   = '0;
                    d.dout  = cmd_bit('0, NCMD - 1);
                end
            end
            CMD: if (tick) begin
                d.sk = ~q.sk;
                if (q.sk) begin
                    if (q.cnt == CW'(NCMD - 1)) begin
                        d.phase = DATA;
                        d.cnt   = '0;
                        d.dout  = 1'b0;
                    end else begin
                        d.cnt  = q.cnt + 1'b1;
                        d.dout = cmd_bit(q.idx, NCMD - 2 - int'(q.cnt));
                    end
                end
            end
            DATA: if (tick) begin
                d.sk = ~q.sk;
                if (q.sk) begin
                    d.sh  = {q.sh[DATA_W-2:0], di_i};
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt == CW'(DATA_W)) begin
                        d.phase = GAP;
                        d.cs    = 1'b0;
                        d.valid = 1'b1;
                    end
                end
            end
            GAP: if (tick) begin
                if (q.idx == IW'(WORDS - 1)) begin
                    d.phase = IDLE;
                    d.done  = 1'b1;
                end else begin
                    d.phase = CMD;
                    d.idx   = q.idx + 1'b1;
                    d.cnt   = '0;
                    d.cs    = 1'b1;
                    d.dout  = cmd_bit(IW'(q.idx + 1'b1), NCMD - 1);
                end
            end
            default: d.phase = IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy_o       = (q.phase != IDLE);
    assign done_o       = q.done;
    assign cs_o         = q.cs;
    assign sk_o         = q.sk;
    assign do_o         = q.dout;
    assign word_valid_o = q.valid;
    assign word_idx_o   = q.idx;
    assign word_o       = q.sh;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_cs_idle;
        q.phase == IDLE |-> !q.cs && !q.sk;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("serial select active while idle");

    property p_sk_rate;
        !tick && q.phase != IDLE |=> $stable(q.sk);
    endproperty
    a_sk_rate: assert property (p_sk_rate)
        else $error("serial clock moved between ticks");

endmodule

// ===== design/strap_config_top.sv
// Function
// - outside reset and the rom read, low data pins carry the memory data bus
// - during reset, first config register loads from low data pins
// - on reset release, read serial rom through three shared pins when address pin 10 selects rom
// - rom contents appear in the station address prom window
// - after the rom read, serial pins return to data bits 0 to 2
// - outside reset and the rom read, high data pins carry the upper data byte
// - during reset, second config register loads from high data pins
// - outside reset, drive memory address bits 1 to 8
// - during reset, third config register loads from address pins 1-8
// - outside reset, drive memory address bits 9 to 13
// - during reset, address pin 9 selects 16 or 8 bit host bus
// - during reset, address pin 10 selects rom or pin configuration
// - during reset, address pins 11-13 load signature bits 5 to 7
module strap_config_top #(
    parameter int WORDS = strap_pkg::ROM_WORDS,
    parameter int HALF  = strap_pkg::ROM_HALF_CYC
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire strap_pkg::wb_req_s   wb_req_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // memory user port
    input  wire strap_pkg::mem_req_s  mem_req_i,
    output logic [15:0]               mem_rdata_o,
    // shared data pins
    input  wire logic [15:0]          data_pin_i,
    output logic [15:0]               data_pin_o,
    output logic [15:0]               data_pin_oe_o,
    // shared address pins
    input  wire logic [13:1]          addr_pin_i,
    output logic [13:1]               addr_pin_o,
    output logic [13:1]               addr_pin_oe_o,
    // serial rom select
    output logic                      rom_select_o,
    // configuration
    output strap_pkg::strap_cfg_s     strap_cfg_o,
    output logic                      load_busy_o
);
    localparam int IW = $clog2(WORDS);

    typedef struct packed {
        strap_pkg::strap_cfg_s      cfg;
        logic [WORDS-1:0][15:0]     prom;
        logic                       load_pend;
        logic                       loading;
        logic                       loaded;
        logic                       ack;
        logic [31:0]                rdata;
        logic [15:0]                data_o;
        logic [15:0]                data_oe;
        logic [13:1]                addr_o;
        logic [13:1]                addr_oe;
        logic                       rom_sel;
        logic [15:0]                mem_rdata;
    } top_s;

    top_s q, d;

    logic          start;
    logic          sw_reload;
    logic          rom_busy;
    logic          rom_done;
    logic          rom_cs;
    logic          rom_sk;
    logic          rom_do;
    logic          rom_valid;
    logic [IW-1:0] rom_idx;
    logic [15:0]   rom_word;
    logic          bus_req;

    // ==========================================================
    // serial rom reader
    serial_rom_reader #(
        .WORDS  (WORDS),
        .ADDR_W (strap_pkg::ROM_ADDR_W),
        .DATA_W (16),
        .HALF   (HALF)
    ) u_reader (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .start_i      (start),
        .busy_o       (rom_busy),
        .done_o       (rom_done),
        .cs_o         (rom_cs),
        .sk_o         (rom_sk),
        .do_o         (rom_do),
        .di_i         (data_pin_i[1]),
        .word_valid_o (rom_valid),
        .word_idx_o   (rom_idx),
        .word_o       (rom_word)
    );

    // ==========================================================
    // register decode
    function automatic logic is_prom(input logic [7:0] adr);
        is_prom = (adr[7:6] == strap_pkg::OFS_PROM) && (adr[1:0] == 2'h0)
                  && (int'(adr[5:2]) < WORDS);
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] adr,
                                              input top_s      s);
        read_word = 32'h0;
        if (is_prom(adr)) begin
            read_word = {16'h0, s.prom[adr[5:2]]};
        end else begin
            case (adr)
                strap_pkg::OFS_CTRL: begin
                    read_word[strap_pkg::ST_BUSY]    = s.loading;
                    read_word[strap_pkg::ST_DONE]    = s.loaded;
                    read_word[strap_pkg::ST_WIDTH16] = s.cfg.host_width;
                    read_word[strap_pkg::ST_SRC_ROM] = s.cfg.cfg_source;
                end
                strap_pkg::OFS_FIRST:  read_word = {24'h0, s.cfg.first};
                strap_pkg::OFS_SECOND: read_word = {24'h0, s.cfg.second};
                strap_pkg::OFS_THIRD:  read_word = {24'h0, s.cfg.third};
                strap_pkg::OFS_SIGN:
                    read_word[strap_pkg::SIGN_LSB +: 3] = s.cfg.signature;
                default: read_word = 32'h0;
            endcase
        end
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        d       = q;
        bus_req = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
        d.ack   = bus_req;
        if (bus_req) begin
            d.rdata = read_word(wb_req_i.adr, q);
        end

        sw_reload = bus_req && wb_req_i.we && wb_req_i.sel[0]
                    && (wb_req_i.adr == strap_pkg::OFS_CTRL)
                    && wb_req_i.dat[strap_pkg::CTRL_RELOAD];

        // rom read after reset release when the source strap asks
        // start rom read
        start       = !q.loading && (q.load_pend || sw_reload);
        d.load_pend = 1'b0;
        if (start) begin
            d.loading = 1'b1;
            d.loaded  = 1'b0;
        end
        if (rom_done) begin
            d.loading = 1'b0;
            d.loaded  = 1'b1;
        end

        if (rom_valid) begin
            d.prom[rom_idx] = rom_word;
            if (rom_idx == '0) begin
                d.cfg.first  = rom_word[7:0];
                d.cfg.second = rom_word[15:8];
            end
            if (int'(rom_idx) == 1) begin
                d.cfg.third = rom_word[7:0];
            end
        end

        d.addr_oe = '1;
        d.addr_o  = mem_req_i.addr;

        if (q.loading) begin
            // serial pins on data bits 0..2
            d.data_oe   = strap_pkg::SERIAL_OE;
            d.data_o    = {13'h0, rom_sk, 1'b0, rom_do};
            d.rom_sel   = rom_cs;
        end else begin
            d.rom_sel   = 1'b0;
            d.data_oe   = mem_req_i.write ? 16'hffff : 16'h0000;
            d.data_o    = mem_req_i.wdata;
            if (!mem_req_i.write) begin
                d.mem_rdata = data_pin_i;
            end
        end
    end

    // ==========================================================
    // registers, straps sampled on every clock edge during reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.cfg.first      <= data_pin_i[7:0];
            q.cfg.second     <= data_pin_i[15:8];
            q.cfg.third      <= addr_pin_i[8:1];
            q.cfg.host_width <= addr_pin_i[strap_pkg::PIN_WIDTH];
            q.cfg.cfg_source <= addr_pin_i[strap_pkg::PIN_SOURCE];
            q.load_pend      <= addr_pin_i[strap_pkg::PIN_SOURCE];
            q.cfg.signature  <= addr_pin_i[strap_pkg::PIN_SIGN_LSB +: 3];
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign wb_dat_o      = q.rdata;
    assign wb_ack_o      = q.ack;
    assign mem_rdata_o   = q.mem_rdata;
    assign data_pin_o    = q.data_o;
    assign data_pin_oe_o = q.data_oe;
    assign addr_pin_o    = q.addr_o;
    assign addr_pin_oe_o = q.addr_oe;
    assign rom_select_o  = q.rom_sel;
    assign strap_cfg_o   = q.cfg;
    assign load_busy_o   = q.loading;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_first_cap;
        $fell(rst_i) |-> q.cfg.first == $past(data_pin_i[7:0]);
    endproperty
    a_first_cap: assert property (p_first_cap)
        else $error("first config not taken from low data pins");

    property p_second_cap;
        $fell(rst_i) |-> q.cfg.second == $past(data_pin_i[15:8]);
    endproperty
    a_second_cap: assert property (p_second_cap)
        else $error("second config not taken from high data pins");

    property p_third_cap;
        $fell(rst_i) |-> q.cfg.third == $past(addr_pin_i[8:1]);
    endproperty
    a_third_cap: assert property (p_third_cap)
        else $error("third config not taken from address pins");

    property p_misc_cap;
        $fell(rst_i) |-> q.cfg.host_width == $past(addr_pin_i[9])
            && q.cfg.cfg_source == $past(addr_pin_i[10])
            && q.cfg.signature == $past(addr_pin_i[13:11]);
    endproperty
    a_misc_cap: assert property (p_misc_cap)
        else $error("width, source or signature strap lost");

    property p_src_start;
        $fell(rst_i) |-> load_busy_o == 1'b0 ##1
            load_busy_o == $past(q.cfg.cfg_source);
    endproperty
    a_src_start: assert property (p_src_start)
        else $error("rom load does not follow source strap");

    property p_cfg_hold;
        !rom_valid |=> $stable(q.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("captured straps changed without rom word");

    property p_addr_low;
        !$past(rst_i) |-> addr_pin_oe_o[8:1] == 8'hff
            && addr_pin_o[8:1] == $past(mem_req_i.addr[8:1]);
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("low address pins not driven");

    property p_addr_high;
        !$past(rst_i) |-> addr_pin_oe_o[13:9] == 5'h1f
            && addr_pin_o[13:9] == $past(mem_req_i.addr[13:9]);
    endproperty
    a_addr_high: assert property (p_addr_high)
        else $error("high address pins not driven");

    property p_serial_pins;
        q.loading |=> data_pin_oe_o == strap_pkg::SERIAL_OE
            && data_pin_o[2] == $past(rom_sk)
            && data_pin_o[0] == $past(rom_do);
    endproperty
    a_serial_pins: assert property (p_serial_pins)
        else $error("serial pins not mapped to data bits");

    property p_data_low;
        !q.loading && mem_req_i.write |=> data_pin_oe_o[7:0] == 8'hff
            && data_pin_o[7:0] == $past(mem_req_i.wdata[7:0]);
    endproperty
    a_data_low: assert property (p_data_low)
        else $error("low data byte not on bus");

    property p_data_high;
        !q.loading && mem_req_i.write |=> data_pin_oe_o[15:8] == 8'hff
            && data_pin_o[15:8] == $past(mem_req_i.wdata[15:8]);
    endproperty
    a_data_high: assert property (p_data_high)
        else $error("high data byte not on bus");

    property p_prom_read;
        bus_req && !wb_req_i.we && is_prom(wb_req_i.adr) |=>
            wb_ack_o && wb_dat_o == {16'h0, $past(q.prom[wb_req_i.adr[5:2]])};
    endproperty
    a_prom_read: assert property (p_prom_read)
        else $error("prom window read wrong word");

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held longer than one cycle");

    c_load_done: cover property ($rose(q.loaded));
    c_sw_reload: cover property (sw_reload && !q.loading);
    c_prom_read: cover property (bus_req && is_prom(wb_req_i.adr));

endmodule
